// ==== rtl/pdr_pkg.sv ====
// Constants for the clock-multiplier and converter control bank.
// Assumes a 50 MHz system clock and a slow serial control port.
package pdr_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [4:0] ADDR_PLL = 5'h04;
  localparam logic [4:0] ADDR_IDAC = 5'h05;
  localparam logic [4:0] ADDR_AUX1 = 5'h06;
  localparam logic [4:0] ADDR_QDAC = 5'h07;
  // ----------------------------------------
  // Serial frame layout
  // ----------------------------------------
  localparam int INSTR_READ_BIT = 7;
  localparam logic [4:0] INSTR_LAST = 5'h07;
  localparam logic [4:0] PLL_LAST = 5'h17;
  localparam logic [4:0] CONV_LAST = 5'h0f;
  // ----------------------------------------
  // Clock-multiplier field positions
  // ----------------------------------------
  localparam int VCOV_HI = 23;
  localparam int VCOV_LO = 21;
  localparam int BW_HI = 20;
  localparam int BW_LO = 16;
  localparam int PLL_EN = 15;
  localparam int VDIV_HI = 14;
  localparam int VDIV_LO = 13;
  localparam int LDIV_HI = 12;
  localparam int LDIV_LO = 11;
  localparam int BIAS_HI = 10;
  localparam int BIAS_LO = 8;
  localparam int BAND_HI = 7;
  localparam int BAND_LO = 2;
  localparam int DRV_HI = 1;
  localparam int DRV_LO = 0;
  // ----------------------------------------
  // Converter field positions
  // ----------------------------------------
  localparam int CONV_SLEEP = 15;
  localparam int CONV_PD = 14;
  localparam int AUX_SIGN = 15;
  localparam int AUX_DIR = 14;
  localparam int AUX_PD = 13;
  localparam int GAIN_HI = 9;
  // ----------------------------------------
  // Writable masks and reset values
  // ----------------------------------------
  localparam logic [23:0] PLL_WR_MASK = 24'h1fffff;
  localparam logic [23:0] CONV_WR_MASK = 24'h00c3ff;
  localparam logic [23:0] AUX_WR_MASK = 24'h00e3ff;
  localparam logic [23:0] PLL_RST = 24'h000000;
  localparam logic [23:0] CONV_RST = 24'h000000;
  localparam logic [23:0] AUX_RST = 24'h000000;
  // ----------------------------------------
  // Codes of note
  // ----------------------------------------
  localparam logic [2:0] VCOV_CENTER = 3'h3;
  localparam logic [4:0] BW_ADVISED = 5'h0f;
  localparam logic [2:0] BIAS_ADVISED = 3'h3;
  localparam logic [1:0] DRV_ADVISED = 2'h3;
  localparam logic [3:0] VDIV_1 = 4'h1;
  localparam logic [3:0] VDIV_2 = 4'h2;
  localparam logic [3:0] VDIV_4 = 4'h4;
  localparam logic [3:0] VDIV_8 = 4'h8;
  localparam logic [4:0] LDIV_2 = 5'h02;
  localparam logic [4:0] LDIV_4 = 5'h04;
  localparam logic [4:0] LDIV_8 = 5'h08;
  localparam logic [4:0] LDIV_16 = 5'h10;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_INSTR = 5'b00010,
    ST_LOAD = 5'b00100,
    ST_DATA = 5'b01000,
    ST_DONE = 5'b10000
  } pdr_state_t;
endpackage : pdr_pkg

// ==== rtl/pdr_bus_if.sv ====
// Link between the serial engine and the register bank.
// Both ends run on the same system clock.
`timescale 1ns/100ps
interface pdr_bus_if;
  logic wr_stb;
  logic [4:0] addr;
  logic [23:0] wdata;
  logic [2:0] vco_code;
  logic [23:0] rdata;
  logic [23:0] pll_q;
  logic [23:0] idac_q;
  logic [23:0] aux_q;
  logic [23:0] qdac_q;
  modport master (
    output wr_stb, addr, wdata, vco_code,
    input rdata, pll_q, idac_q, aux_q, qdac_q
  );
  modport slave (
    input wr_stb, addr, wdata, vco_code,
    output rdata, pll_q, idac_q, aux_q, qdac_q
  );
endinterface : pdr_bus_if

// ==== rtl/pdr_reg_bank.sv ====
// Storage for the four analog control registers and their readback.
// Assumes write strobes and synchronised inputs from the serial engine.
`timescale 1ns/100ps
module pdr_reg_bank
  import pdr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  pdr_bus_if.slave bus
);
  import pdr_pkg::*;

  logic [23:0] pll_r;
  logic [23:0] idac_r;
  logic [23:0] aux_r;
  logic [23:0] qdac_r;
  logic wr_pll;
  logic wr_idac;
  logic wr_aux;
  logic wr_qdac;
  logic [23:0] pll_view;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign wr_pll = bus.wr_stb && (bus.addr == ADDR_PLL);
  assign wr_idac = bus.wr_stb && (bus.addr == ADDR_IDAC);
  assign wr_aux = bus.wr_stb && (bus.addr == ADDR_AUX1);
  assign wr_qdac = bus.wr_stb && (bus.addr == ADDR_QDAC);
  assign pll_view = {bus.vco_code, pll_r[BW_HI:0]};

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // reserved bits masked off
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pll_r <= PLL_RST;
      idac_r <= CONV_RST;
      aux_r <= AUX_RST;
      qdac_r <= CONV_RST;
    end else begin
      if (wr_pll) pll_r <= bus.wdata & PLL_WR_MASK;
      if (wr_idac) idac_r <= bus.wdata & CONV_WR_MASK;
      if (wr_aux) aux_r <= bus.wdata & AUX_WR_MASK;
      if (wr_qdac) qdac_r <= bus.wdata & CONV_WR_MASK;
    end
  end

  // ----------------------------------------
  // Readback
  // ----------------------------------------
  // read back last written, except PLL top three bits show the synced tune code
  assign bus.rdata = (bus.addr == ADDR_PLL) ? pll_view :
                     (bus.addr == ADDR_IDAC) ? idac_r :
                     (bus.addr == ADDR_AUX1) ? aux_r :
                     (bus.addr == ADDR_QDAC) ? qdac_r : 24'h000000;
  assign bus.pll_q = pll_r;
  assign bus.idac_q = idac_r;
  assign bus.aux_q = aux_r;
  assign bus.qdac_q = qdac_r;
endmodule : pdr_reg_bank

// ==== rtl/pdr_ctrl_top.sv ====
// Serial control port and analog control outputs for the clock
// multiplier, the in-phase, quadrature and first auxiliary converters.
// Assumes serial pins from outside the clock domain, slower than clock/8.
//
// How it works
// - VCO voltage code read only, 011 centered
// - Loop bandwidth field, larger means lower
// - Enable picks multiplier over reference clock
// - Oscillator divider codes give 1,2,4,8
// - Loop divider codes give 2,4,8,16
// - Three-bit oscillator bias current field
// - Band select passed straight to oscillator
// - Two-bit oscillator drive strength field
// - In-phase sleep bit, default active
// - In-phase power-down bit, default active
// - In-phase ten-bit gain, four reserved above
// - Aux sign bit chooses active pin
// - Aux direction bit: source or sink
// - Aux power-down bit, three reserved below
// - Aux ten-bit data code to converter
// - Quadrature sleep bit, default active
// - Quadrature power-down bit, default active
// - Quadrature ten-bit gain, four reserved above
// - Converter registers two bytes, wired out
// - Multiplier register three bytes, wired out
`timescale 1ns/100ps
module pdr_ctrl_top
  import pdr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_out,
  input wire logic [2:0] vco_tune_code_in,
  output logic vco_centered_out,
  output logic [4:0] pll_loop_bw_out,
  output logic pll_enable_out,
  output logic ref_clock_direct_out,
  output logic [1:0] vco_div_code_out,
  output logic [3:0] vco_div_ratio_out,
  output logic [1:0] loop_div_code_out,
  output logic [4:0] loop_div_ratio_out,
  output logic [2:0] vco_bias_out,
  output logic [5:0] vco_band_out,
  output logic [1:0] vco_drive_out,
  output logic i_sleep_out,
  output logic i_pd_out,
  output logic i_active_out,
  output logic [9:0] i_gain_out,
  output logic aux1_pos_pin_en_out,
  output logic aux1_neg_pin_en_out,
  output logic aux1_sink_out,
  output logic aux1_pd_out,
  output logic [9:0] aux1_data_out,
  output logic q_sleep_out,
  output logic q_pd_out,
  output logic q_active_out,
  output logic [9:0] q_gain_out
);
  import pdr_pkg::*;

  pdr_bus_if bus ();

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic sclk_s1;
  logic sclk_s2;
  logic sclk_s3;
  logic cs_n_s1;
  logic cs_n_s2;
  logic sdi_s1;
  logic sdi_s2;
  logic [2:0] vco_s1;
  logic [2:0] vco_s2;
  logic [2:0] vco_s3;
  logic [2:0] vco_q;

  // Bits sync one by one; a word is kept only when two samples agree
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      vco_s1 <= 3'h0;
      vco_s2 <= 3'h0;
      vco_s3 <= 3'h0;
      vco_q <= 3'h0;
    end else begin
      sclk_s1 <= spi_sclk_in;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_n_s1 <= spi_cs_n_in;
      cs_n_s2 <= cs_n_s1;
      sdi_s1 <= spi_sdi_in;
      sdi_s2 <= sdi_s1;
      vco_s1 <= vco_tune_code_in;
      vco_s2 <= vco_s1;
      vco_s3 <= vco_s2;
      if (vco_s2 == vco_s3) vco_q <= vco_s2;
    end
  end

  // ----------------------------------------
  // Frame decode
  // ----------------------------------------
  pdr_state_t state_r;
  pdr_state_t state_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [23:0] sh_in_r;
  logic [23:0] sh_out_r;
  logic [23:0] sh_out_nxt;
  logic rd_r;
  logic rd_nxt;
  logic [4:0] addr_r;
  logic [4:0] addr_nxt;
  logic wr_stb_r;
  logic wr_stb_nxt;
  logic [23:0] wdata_r;

  logic sclk_rise;
  logic cs_act;
  logic [23:0] sh_in_next;
  logic addr_is_pll;
  logic addr_mapped;
  logic [4:0] data_last;
  logic instr_done;
  logic data_done;
  logic [23:0] rd_aligned;

  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign cs_act = ~cs_n_s2;
  assign sh_in_next = {sh_in_r[22:0], sdi_s2};
  assign addr_is_pll = (addr_r == ADDR_PLL);
  assign addr_mapped = addr_is_pll || (addr_r == ADDR_IDAC) ||
                       (addr_r == ADDR_AUX1) || (addr_r == ADDR_QDAC);
  assign data_last = addr_is_pll ? PLL_LAST : CONV_LAST;
  assign instr_done = sclk_rise && (cnt_r == INSTR_LAST);
  assign data_done = sclk_rise && (cnt_r == data_last);
  // Short registers sit left aligned so the MSB leaves first
  assign rd_aligned = addr_is_pll ? bus.rdata : {bus.rdata[15:0], 8'h00};

  // ----------------------------------------
  // Frame state machine
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    rd_nxt = rd_r;
    addr_nxt = addr_r;
    sh_out_nxt = sh_out_r;
    wr_stb_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = 5'h00;
        if (cs_act) begin
          state_nxt = ST_INSTR;
        end
      end
      ST_INSTR: begin
        if (sclk_rise) begin
          cnt_nxt = cnt_r + 5'h01;
        end
        if (instr_done) begin
          rd_nxt = sh_in_next[INSTR_READ_BIT];
          addr_nxt = sh_in_next[4:0];
          cnt_nxt = 5'h00;
          state_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // Unmapped reads shift out zeros
        sh_out_nxt = rd_aligned;
        state_nxt = ST_DATA;
      end
      ST_DATA: begin
        if (sclk_rise) begin
          cnt_nxt = cnt_r + 5'h01;
          sh_out_nxt = {sh_out_r[22:0], 1'b0};
        end
        if (data_done) begin
          // Writes to unmapped addresses vanish
          wr_stb_nxt = ~rd_r & addr_mapped;
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        // Extra clocks ignored until chip select drops
        cnt_nxt = 5'h00;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Abort: partial frames never write
    if (!cs_act) begin
      state_nxt = ST_IDLE;
      wr_stb_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
      rd_r <= 1'b0;
      addr_r <= 5'h00;
      sh_out_r <= 24'h000000;
      wr_stb_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      addr_r <= addr_nxt;
      sh_out_r <= sh_out_nxt;
      wr_stb_r <= wr_stb_nxt;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sh_in_r <= 24'h000000;
      wdata_r <= 24'h000000;
    end else begin
      if (sclk_rise) sh_in_r <= sh_in_next;
      if (data_done) wdata_r <= sh_in_next;
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  assign spi_sdo_out = sh_out_r[23];
  assign spi_sdo_oe_out = rd_r && (state_r == ST_DATA);

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  assign bus.wr_stb = wr_stb_r;
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.vco_code = vco_q;

  pdr_reg_bank u_bank (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .bus(bus)
  );

  // ----------------------------------------
  // Divider decode
  // ----------------------------------------
  logic [1:0] vdiv_code;
  logic [1:0] ldiv_code;
  logic [3:0] vdiv_ratio;
  logic [4:0] ldiv_ratio;

  assign vdiv_code = bus.pll_q[VDIV_HI:VDIV_LO];
  assign ldiv_code = bus.pll_q[LDIV_HI:LDIV_LO];
  assign vdiv_ratio = (vdiv_code == 2'h0) ? VDIV_1 :
                      (vdiv_code == 2'h1) ? VDIV_2 :
                      (vdiv_code == 2'h2) ? VDIV_4 : VDIV_8;
  assign ldiv_ratio = (ldiv_code == 2'h0) ? LDIV_2 :
                      (ldiv_code == 2'h1) ? LDIV_4 :
                      (ldiv_code == 2'h2) ? LDIV_8 : LDIV_16;

  // ----------------------------------------
  // Analog control outputs
  // ----------------------------------------
  // Outputs are decoded from stored fields, one cycle behind the bank; the centered flag comes from the tune synchronisers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      vco_centered_out <= 1'b0;
      pll_loop_bw_out <= 5'h00;
      pll_enable_out <= 1'b0;
      ref_clock_direct_out <= 1'b1;
      vco_div_code_out <= 2'h0;
      vco_div_ratio_out <= VDIV_1;
      loop_div_code_out <= 2'h0;
      loop_div_ratio_out <= LDIV_2;
      vco_bias_out <= 3'h0;
      vco_band_out <= 6'h00;
      vco_drive_out <= 2'h0;
    end else begin
      vco_centered_out <= (vco_s2 == VCOV_CENTER) && (vco_s3 == VCOV_CENTER);
      pll_loop_bw_out <= bus.pll_q[BW_HI:BW_LO];
      pll_enable_out <= bus.pll_q[PLL_EN];
      ref_clock_direct_out <= ~bus.pll_q[PLL_EN];
      vco_div_code_out <= vdiv_code;
      vco_div_ratio_out <= vdiv_ratio;
      loop_div_code_out <= ldiv_code;
      loop_div_ratio_out <= ldiv_ratio;
      vco_bias_out <= bus.pll_q[BIAS_HI:BIAS_LO];
      vco_band_out <= bus.pll_q[BAND_HI:BAND_LO];
      vco_drive_out <= bus.pll_q[DRV_HI:DRV_LO];
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      i_sleep_out <= 1'b0;
      i_pd_out <= 1'b0;
      i_active_out <= 1'b1;
      i_gain_out <= 10'h000;
      q_sleep_out <= 1'b0;
      q_pd_out <= 1'b0;
      q_active_out <= 1'b1;
      q_gain_out <= 10'h000;
    end else begin
      i_sleep_out <= bus.idac_q[CONV_SLEEP];
      i_pd_out <= bus.idac_q[CONV_PD];
      i_active_out <= ~(bus.idac_q[CONV_SLEEP] | bus.idac_q[CONV_PD]);
      i_gain_out <= bus.idac_q[GAIN_HI:0];
      q_sleep_out <= bus.qdac_q[CONV_SLEEP];
      q_pd_out <= bus.qdac_q[CONV_PD];
      q_active_out <= ~(bus.qdac_q[CONV_SLEEP] | bus.qdac_q[CONV_PD]);
      q_gain_out <= bus.qdac_q[GAIN_HI:0];
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      aux1_pos_pin_en_out <= 1'b1;
      aux1_neg_pin_en_out <= 1'b0;
      aux1_sink_out <= 1'b0;
      aux1_pd_out <= 1'b0;
      aux1_data_out <= 10'h000;
    end else begin
      aux1_pos_pin_en_out <= ~bus.aux_q[AUX_SIGN];
      aux1_neg_pin_en_out <= bus.aux_q[AUX_SIGN];
      aux1_sink_out <= bus.aux_q[AUX_DIR];
      aux1_pd_out <= bus.aux_q[AUX_PD];
      aux1_data_out <= bus.aux_q[GAIN_HI:0];
    end
  end
endmodule : pdr_ctrl_top

// ==== testbench/pdr_ctrl_chk.sv ====
// Port-level assertions for the analog control bank.
// Assumes one clock domain and bind onto every pdr_ctrl_top.
`timescale 1ns/100ps
module pdr_ctrl_chk
  import pdr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdo_oe_out,
  input wire logic [2:0] vco_tune_code_in,
  input wire logic vco_centered_out,
  input wire logic pll_enable_out,
  input wire logic ref_clock_direct_out,
  input wire logic [1:0] vco_div_code_out,
  input wire logic [3:0] vco_div_ratio_out,
  input wire logic [1:0] loop_div_code_out,
  input wire logic [4:0] loop_div_ratio_out,
  input wire logic i_sleep_out,
  input wire logic i_pd_out,
  input wire logic i_active_out,
  input wire logic [9:0] i_gain_out,
  input wire logic aux1_pos_pin_en_out,
  input wire logic aux1_neg_pin_en_out,
  input wire logic q_sleep_out,
  input wire logic q_pd_out,
  input wire logic q_active_out
);
  import pdr_pkg::*;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  // Five samples cover the three tune sync stages plus the output register
  sequence s_port_idle;
    spi_cs_n_in [*5];
  endsequence
  sequence s_tune_center;
    (vco_tune_code_in == VCOV_CENTER) [*5];
  endsequence
  sequence s_tune_off;
    (vco_tune_code_in != VCOV_CENTER) [*5];
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ref_clk_pick: assert property (ref_clock_direct_out == !pll_enable_out)
    else $error("reference path not inverse of enable");
  a_vco_div_ratio: assert property (vco_div_ratio_out == (4'h1 << vco_div_code_out))
    else $error("oscillator divider ratio wrong");
  a_loop_div_ratio: assert property (loop_div_ratio_out == (5'h02 << loop_div_code_out))
    else $error("loop divider ratio wrong");
  a_vco_center_hi: assert property (s_tune_center |-> vco_centered_out)
    else $error("centered flag missing");
  a_vco_center_lo: assert property (s_tune_off |-> !vco_centered_out)
    else $error("centered flag false");
  a_i_active_sum: assert property (i_active_out == !(i_sleep_out || i_pd_out))
    else $error("in-phase active wrong");
  a_q_active_sum: assert property (q_active_out == !(q_sleep_out || q_pd_out))
    else $error("quadrature active wrong");
  a_aux_pin_pick: assert property (aux1_pos_pin_en_out != aux1_neg_pin_en_out)
    else $error("aux pins not exclusive");
  a_idle_no_drive: assert property (s_port_idle |-> !spi_sdo_oe_out)
    else $error("serial out driven while idle");
  a_idle_hold: assert property (s_port_idle |=> $stable({pll_enable_out, vco_div_code_out,
    loop_div_code_out, i_gain_out, i_sleep_out, i_pd_out, q_sleep_out, aux1_neg_pin_en_out}))
    else $error("outputs moved while port idle");
  a_reset_vals: assert property ($fell(rst_in) |-> ref_clock_direct_out && i_active_out
    && q_active_out && aux1_pos_pin_en_out && vco_div_ratio_out == VDIV_1
    && loop_div_ratio_out == LDIV_2)
    else $error("reset values wrong");
endmodule : pdr_ctrl_chk

bind pdr_ctrl_top pdr_ctrl_chk i_chk (.*);

// ==== testbench/pdr_ctrl_top_tb.sv ====
// Self-checking bench for the analog control bank.
// Drives the serial port pins directly; no partner model.
`timescale 1ns/100ps
module pdr_ctrl_top_tb;
  import pdr_pkg::*;
  logic clock_in, rst_in, spi_sclk_in, spi_cs_n_in, spi_sdi_in, spi_sdo_out, spi_sdo_oe_out;
  logic [2:0] vco_tune_code_in, vco_bias_out;
  logic vco_centered_out, pll_enable_out, ref_clock_direct_out;
  logic [4:0] pll_loop_bw_out, loop_div_ratio_out;
  logic [1:0] vco_div_code_out, loop_div_code_out, vco_drive_out;
  logic [3:0] vco_div_ratio_out;
  logic [5:0] vco_band_out;
  logic i_sleep_out, i_pd_out, i_active_out, q_sleep_out, q_pd_out, q_active_out;
  logic aux1_pos_pin_en_out, aux1_neg_pin_en_out, aux1_sink_out, aux1_pd_out;
  logic [9:0] i_gain_out, aux1_data_out, q_gain_out;
  int errors, num_checks, cycles;
  logic [23:0] rd;

  pdr_ctrl_top i_dut (.*);

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask : tick

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Six clocks per phase keeps well above the sampled-port minimum
  task automatic spi_bit(input logic b, output logic s);
    spi_sdi_in = b;
    tick(6);
    // Gated by the enable so an undriven read shows up as zeros
    s = spi_sdo_out & spi_sdo_oe_out;
    spi_sclk_in = 1'b1;
    tick(6);
    spi_sclk_in = 1'b0;
  endtask : spi_bit

  // Sends n data bits; fewer than the register width aborts the frame
  task automatic xfer(input logic is_rd, input logic [4:0] a, input logic [23:0] d,
                      input int n, output logic [23:0] q);
    logic [7:0] ins;
    logic s;
    ins = {is_rd, 2'b00, a};
    q = '0;
    spi_cs_n_in = 1'b0;
    tick(4);
    for (int i = 7; i >= 0; i--) spi_bit(ins[i], s);
    for (int i = n - 1; i >= 0; i--) begin
      spi_bit(d[i], s);
      q[i] = s;
    end
    tick(8);
    spi_cs_n_in = 1'b1;
    tick(8);
  endtask : xfer

  task automatic chk_defaults;
    check({pll_enable_out, ref_clock_direct_out, vco_div_ratio_out, loop_div_ratio_out,
      i_active_out, q_active_out, aux1_pos_pin_en_out, aux1_neg_pin_en_out, aux1_sink_out,
      aux1_pd_out}, {1'b0, 1'b1, VDIV_1, LDIV_2, 3'h7, 3'h0});
    check({i_sleep_out, i_pd_out, q_sleep_out, q_pd_out, i_gain_out}, 24'h0);
    xfer(1'b1, ADDR_IDAC, 24'h0, 16, rd);
    check(rd, 24'h0);
  endtask : chk_defaults

  task automatic final_report;
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // Frames take about 400 cycles; the run needs well under 20000
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      final_report();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [4:0] bw;
    logic [1:0] k2, ld;
    logic [2:0] bias, tune;
    logic [5:0] band;
    logic [23:0] d;
    logic [15:0] v;
    logic [15:0] vals [3];
    vals = '{16'hffff, 16'h5555, 16'ha2aa};
    errors = 0;
    num_checks = 0;
    cycles = 0;
    rst_in = 1'b1;
    spi_sclk_in = 1'b0;
    spi_cs_n_in = 1'b1;
    spi_sdi_in = 1'b0;
    vco_tune_code_in = 3'h0;
    tick(8);
    rst_in = 1'b0;
    tick(4);
    chk_defaults();
    for (int k = 0; k < 4; k++) begin
      k2 = k[1:0];
      bw = BW_ADVISED + 5'(k);
      ld = ~k2;
      bias = BIAS_ADVISED + 3'(k);
      band = 6'h3f >> k;
      tune = 3'(k + 2);
      vco_tune_code_in = tune;
      d = {3'h7, bw, k2[0], k2, ld, bias, band, k2};
      xfer(1'b0, ADDR_PLL, d, 24, rd);
      check({pll_loop_bw_out, pll_enable_out, ref_clock_direct_out, vco_div_code_out,
        vco_div_ratio_out, loop_div_code_out, loop_div_ratio_out},
        {bw, k2[0], ~k2[0], k2, 4'h1 << k2, ld, 5'h02 << ld});
      check({vco_bias_out, vco_band_out, vco_drive_out}, {bias, band, k2});
      check(vco_centered_out, tune == VCOV_CENTER);
      xfer(1'b1, ADDR_PLL, 24'h0, 24, rd);
      check(rd, {tune, d[20:0]});
    end
    for (int a = 5; a < 8; a++) begin
      for (int j = 0; j < 3; j++) begin
        v = vals[j];
        xfer(1'b0, 5'(a), {8'h00, v}, 16, rd);
        xfer(1'b1, 5'(a), 24'h0, 16, rd);
        check(rd, {8'h00, v} & ((a == 6) ? AUX_WR_MASK : CONV_WR_MASK));
        case (a)
          5: check({i_sleep_out, i_pd_out, i_active_out, i_gain_out},
            {v[15], v[14], ~(v[15] | v[14]), v[9:0]});
          6: check({aux1_pos_pin_en_out, aux1_neg_pin_en_out, aux1_sink_out,
            aux1_pd_out, aux1_data_out}, {~v[15], v[15], v[14], v[13], v[9:0]});
          default: check({q_sleep_out, q_pd_out, q_active_out, q_gain_out},
            {v[15], v[14], ~(v[15] | v[14]), v[9:0]});
        endcase
      end
    end
    // Short frame must leave the last written value
    xfer(1'b0, ADDR_IDAC, 24'h00ffff, 4, rd);
    xfer(1'b1, ADDR_IDAC, 24'h0, 16, rd);
    check(rd, {8'h00, vals[2]} & CONV_WR_MASK);
    // Unmapped address that would alias 0x07 if the top bits were dropped
    xfer(1'b0, 5'h0f, 24'h00ffff, 16, rd);
    xfer(1'b1, 5'h0f, 24'h0, 16, rd);
    check(rd, 24'h0);
    check(q_gain_out, vals[2][9:0]);
    rst_in = 1'b1;
    tick(8);
    rst_in = 1'b0;
    tick(4);
    chk_defaults();
    final_report();
  end
endmodule : pdr_ctrl_top_tb
